// ### hw/uec_consts.svh
// event codes, unit masks, reset values and widths for the uncore event qualifier
`ifndef UEC_CONSTS_SVH
`define UEC_CONSTS_SVH

// event numbers
`define UEC_EV_SF_STALL   8'h40
`define UEC_EV_MF_STALL   8'h41
`define UEC_EV_TX_HDR     8'h42
`define UEC_EV_RX_PROBE   8'h43
`define UEC_EV_DRAM_ACT   8'h60
`define UEC_EV_DRAM_PCL   8'h61

// unit masks that select a whole link on the stall events
`define UEC_UM_LINK0_ALL  8'h07
`define UEC_UM_LINK1_ALL  8'h38

// highest legal unit mask bit per event group
`define UEC_UM_STALL_MAX  8'h20
`define UEC_UM_HDR_MAX    8'h08
`define UEC_UM_RX_MAX     8'h02
`define UEC_UM_DRAM_MAX   8'h04

// bit positions inside the single flit stall condition vector
`define UEC_SF_L0_SNOOP   1
`define UEC_SF_L1_SNOOP   4
`define UEC_SF_L1_NODATA  5

// reset values of the selection and the counter width
`define UEC_RST_EVENT     8'h00
`define UEC_RST_UMASK     8'h00
`define UEC_CNT_WIDTH     48

`endif

// ### hw/uec_pkg.sv
// types shared by the uncore event qualifier
package uec_pkg;

    // counting state of the block
    typedef enum logic [1:0] {
        UEC_OFF,
        UEC_RUN,
        UEC_HALT
    } uec_state_t;

endpackage

// ### hw/uec_event_decode.sv
// event number and unit mask decode into a legal flag and a one-cycle hit
`timescale 1ns/1ps
`default_nettype none
`include "uec_consts.svh"

module uec_event_decode
    import uec_pkg::*;
(
    input  wire logic [7:0] event_num,   // selected event number
    input  wire logic [7:0] unit_mask,   // selected unit mask
    input  wire logic [5:0] sf_stall,    // single flit stalls, link0 bits 2:0
    input  wire logic [5:0] mf_stall,    // multi flit stalls, link0 bits 2:0
    input  wire logic [3:0] hdr_state,   // full0, busy0, full1, busy1
    input  wire logic [1:0] rx_stall,    // probe tracker stall per link
    input  wire logic [2:0] dram_act,    // page activate per channel
    input  wire logic [2:0] dram_pcl,    // idle close per channel
    output logic            legal,       // encoding is a listed one
    output logic            hit          // a selected condition is true
);

    logic [5:0] sf_m;
    logic [5:0] mf_m;
    logic [5:0] hdr_m;
    logic [5:0] rx_m;
    logic [5:0] act_m;
    logic [5:0] pcl_m;

    // true for a single set bit not above the limit
    function automatic logic one_bit(input logic [7:0] m, input logic [7:0] lim);
        one_bit = (m != 8'h00) && ((m & (m - 8'h01)) == 8'h00) && (m <= lim);
    endfunction

    // per bit gating of each condition by its unit mask bit
    genvar i;
    generate
        for (i = 0; i < 6; i++) begin : g_bit
            assign sf_m[i] = sf_stall[i] & unit_mask[i];
            assign mf_m[i] = mf_stall[i] & unit_mask[i];
            if (i < 4) begin : g_hdr
                assign hdr_m[i] = hdr_state[i] & unit_mask[i];
            end else begin : g_nohdr
                assign hdr_m[i] = 1'b0;
            end
            if (i < 2) begin : g_rx
                assign rx_m[i] = rx_stall[i] & unit_mask[i];
            end else begin : g_norx
                assign rx_m[i] = 1'b0;
            end
            if (i < 3) begin : g_dram
                assign act_m[i] = dram_act[i] & unit_mask[i];
                assign pcl_m[i] = dram_pcl[i] & unit_mask[i];
            end else begin : g_nodram
                assign act_m[i] = 1'b0;
                assign pcl_m[i] = 1'b0;
            end
        end
    endgenerate

    // decode; any selected sub-condition counts once per cycle
    always_comb begin
        legal = 1'b0;
        hit   = 1'b0;
        case (event_num)
            `UEC_EV_SF_STALL: begin
                legal = one_bit(unit_mask, `UEC_UM_STALL_MAX)
                      || unit_mask == `UEC_UM_LINK0_ALL
                      || unit_mask == `UEC_UM_LINK1_ALL;
                hit   = |sf_m;
            end
            `UEC_EV_MF_STALL: begin
                legal = one_bit(unit_mask, `UEC_UM_STALL_MAX)
                      || unit_mask == `UEC_UM_LINK0_ALL
                      || unit_mask == `UEC_UM_LINK1_ALL;
                hit   = |mf_m;
            end
            `UEC_EV_TX_HDR: begin
                legal = one_bit(unit_mask, `UEC_UM_HDR_MAX);
                hit   = |hdr_m;
            end
            `UEC_EV_RX_PROBE: begin
                legal = one_bit(unit_mask, `UEC_UM_RX_MAX);
                hit   = |rx_m;
            end
            `UEC_EV_DRAM_ACT: begin
                legal = one_bit(unit_mask, `UEC_UM_DRAM_MAX);
                hit   = |act_m;
            end
            `UEC_EV_DRAM_PCL: begin
                legal = one_bit(unit_mask, `UEC_UM_DRAM_MAX);
                hit   = |pcl_m;
            end
            default: begin
                legal = 1'b0;
                hit   = 1'b0;
            end
        endcase
    end

endmodule
`default_nettype wire

// ### hw/uec_counter.sv
// wrapping event counter with synchronous clear and wrap pulse
`timescale 1ns/1ps
`default_nettype none
`include "uec_consts.svh"

module uec_counter
    import uec_pkg::*;
#(
    parameter int W = `UEC_CNT_WIDTH     // counter width
)(
    input  wire logic         clk,       // uncore clock
    input  wire logic         reset,     // async reset, active high
    input  wire logic         clear,     // load zero, wins over inc
    input  wire logic         inc,       // add one this edge
    output logic [W-1:0]      count_q,   // current count
    output logic              wrap_q     // one cycle after all ones to zero
);

    logic [W-1:0] count_d;
    logic         wrap_d;

    // next count; clear drops a coinciding increment
    always_comb begin
        count_d = count_q;
        wrap_d  = 1'b0;
        if (clear) begin
            count_d = '0;
        end else if (inc) begin
            count_d = count_q + {{(W-1){1'b0}}, 1'b1};
            wrap_d  = &count_q;
        end
    end

    // count registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
            wrap_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            wrap_q  <= wrap_d;
        end
    end

endmodule
`default_nettype wire

// ### hw/uec_top.sv
// uncore link and dram event qualifier with its count register
//
// Notes on behaviour
// - event 40h mask 10h counts cycles link 1 snoop channel lacks single flit credit.
// - event 40h mask 20h counts cycles link 1 non-data response channel lacks credit.
// - event 40h mask 07h counts cycles any single flit channel of link 0 lacks credit.
// - event 40h mask 38h counts cycles any single flit channel of link 1 lacks credit.
// - credit stalls count even when another channel holds the arbitration grant.
// - event 41h masks 01h and 08h count data response stalls on link 0 and link 1.
// - event 41h masks 02h and 10h count noncoherent bypass stalls on link 0 and 1.
// - event 41h masks 04h and 20h count noncoherent standard stalls on link 0 and 1.
// - event 41h masks 07h and 38h count any multi flit stall on link 0 and link 1.
// - event 42h masks 01h and 04h count header buffer full cycles on link 0 and 1.
// - event 42h masks 02h and 08h count header buffer busy cycles on link 0 and 1.
// - event 60h masks 01h, 02h, 04h count page activates on dram channel 0, 1, 2.
// - event 61h masks 01h and 02h count idle timer page closes on channel 0 and 1.
// - event 61h mask 04h counts idle timer page closes on dram channel 2.
`timescale 1ns/1ps
`default_nettype none
`include "uec_consts.svh"

module uec_top
    import uec_pkg::*;
#(
    parameter int CNT_W = `UEC_CNT_WIDTH                     // counter width
)(
    input  wire logic             clk,                       // uncore clock, 40 MHz
    input  wire logic             reset,                     // async reset, active high
    input  wire logic             cfg_write,                 // load event and mask
    input  wire logic [7:0]       cfg_event,                 // event number to load
    input  wire logic [7:0]       cfg_umask,                 // unit mask to load
    input  wire logic             cnt_enable,                // counting allowed
    input  wire logic             cnt_clear,                 // zero the count
    input  wire logic             freeze_on_wrap,            // stop after wrap
    input  wire logic             wrap_flag_clear,           // clear sticky wrap
    input  wire logic [5:0]       link_tx_single_flit_credit_stall, // per vc
    input  wire logic [5:0]       link_tx_multi_flit_credit_stall,  // per vc
    input  wire logic [3:0]       link_tx_header_buffer_state,      // full/busy
    input  wire logic [1:0]       link_rx_probe_tracker_stall,      // per link
    input  wire logic [2:0]       dram_page_activate_count,         // per chan
    input  wire logic [2:0]       dram_idle_page_close_count,       // per chan
    output logic [CNT_W-1:0]      count,                     // event count
    output logic                  wrap_flag,                 // sticky wrap
    output logic                  sel_legal,                 // selection listed
    output logic                  count_pulse,               // one per counted cycle
    output logic                  counting                   // state is run
);

    ////////////////////////////////////////////////////////////////////////////
    // selection registers

    logic [7:0] event_q;
    logic [7:0] event_d;
    logic [7:0] umask_q;
    logic [7:0] umask_d;

    // a new selection replaces the old one whole
    always_comb begin
        event_d = event_q;
        umask_d = umask_q;
        if (cfg_write) begin
            event_d = cfg_event;
            umask_d = cfg_umask;
        end
    end

    // reset selects no event, so nothing counts until programmed
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            event_q <= `UEC_RST_EVENT;
            umask_q <= `UEC_RST_UMASK;
        end else begin
            event_q <= event_d;
            umask_q <= umask_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // condition decode

    logic legal;
    logic hit;

    // conditions come from logic on this clock, so no synchroniser
    uec_event_decode uec_event_decode_i (
        .event_num (event_q),
        .unit_mask (umask_q),
        .sf_stall  (link_tx_single_flit_credit_stall),
        .mf_stall  (link_tx_multi_flit_credit_stall),
        .hdr_state (link_tx_header_buffer_state),
        .rx_stall  (link_rx_probe_tracker_stall),
        .dram_act  (dram_page_activate_count),
        .dram_pcl  (dram_idle_page_close_count),
        .legal     (legal),
        .hit       (hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // counting state

    uec_state_t state_q;
    uec_state_t state_d;
    logic       wrap;

    // off until enabled; a wrap can freeze it until cleared or disabled
    always_comb begin
        state_d = state_q;
        case (state_q)
            UEC_OFF: begin
                if (cnt_enable) begin
                    state_d = UEC_RUN;
                end
            end
            UEC_RUN: begin
                if (!cnt_enable) begin
                    state_d = UEC_OFF;
                end else if (wrap && freeze_on_wrap) begin
                    state_d = UEC_HALT;
                end
            end
            UEC_HALT: begin
                // clearing the count or dropping enable leaves the frozen state
                if (!cnt_enable) begin
                    state_d = UEC_OFF;
                end else if (cnt_clear) begin
                    state_d = UEC_RUN;
                end
            end
            default: begin
                state_d = UEC_OFF;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= UEC_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // qualified increment

    logic inc_q;
    logic inc_d;
    logic legal_q;
    logic legal_d;

    // one increment per cycle however many sub-conditions are true
    always_comb begin
        legal_d = legal;
        inc_d   = 1'b0;
        if (state_q == UEC_RUN && legal) begin
            inc_d = hit;
        end
        // a freshly written selection must not count the old one's hit
        if (cfg_write) begin
            inc_d = 1'b0;
        end
    end

    // registered so the long decode path stays off the adder
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            inc_q   <= 1'b0;
            legal_q <= 1'b0;
        end else begin
            inc_q   <= inc_d;
            legal_q <= legal_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // count register

    logic [CNT_W-1:0] count_val;

    // an increment already in inc_q still lands in the frozen state; the state check gates only inc_d
    uec_counter #(
        .W (CNT_W)
    ) uec_counter_i (
        .clk     (clk),
        .reset   (reset),
        .clear   (cnt_clear),
        .inc     (inc_q),
        .count_q (count_val),
        .wrap_q  (wrap)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sticky wrap flag

    logic wrap_flag_q;
    logic wrap_flag_d;

    // a wrap in the clearing cycle wins, so no wrap is ever lost
    always_comb begin
        wrap_flag_d = wrap_flag_q;
        if (wrap_flag_clear) begin
            wrap_flag_d = 1'b0;
        end
        if (wrap) begin
            wrap_flag_d = 1'b1;
        end
    end

    // flag register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wrap_flag_q <= 1'b0;
        end else begin
            wrap_flag_q <= wrap_flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops but counting, which is decoded from state_q

    assign count       = count_val;
    assign wrap_flag   = wrap_flag_q;
    assign sel_legal   = legal_q;
    assign count_pulse = inc_q;
    assign counting    = (state_q == UEC_RUN);

endmodule
`default_nettype wire

// ### test/uec_top_monitor.sv
// concurrent checks on the event qualifier top ports
`timescale 1ns/1ps
`default_nettype none

module uec_monitor #(
    parameter int CNT_W = 48                   // counter width
)(
    input wire logic             clk,          // uncore clock
    input wire logic             reset,        // async, active high
    input wire logic             cfg_write,    // selection load
    input wire logic             cnt_enable,   // counting allowed
    input wire logic             cnt_clear,    // zero the count
    input wire logic             wrap_flag_clear, // sticky clear
    input wire logic [5:0]       link_tx_single_flit_credit_stall, // per vc
    input wire logic [5:0]       link_tx_multi_flit_credit_stall,  // per vc
    input wire logic [3:0]       link_tx_header_buffer_state,      // full/busy
    input wire logic [1:0]       link_rx_probe_tracker_stall,      // per link
    input wire logic [2:0]       dram_page_activate_count,         // per chan
    input wire logic [2:0]       dram_idle_page_close_count,       // per chan
    input wire logic [CNT_W-1:0] count,        // event count
    input wire logic             wrap_flag,    // sticky wrap
    input wire logic             sel_legal,    // selection listed
    input wire logic             count_pulse,  // counted cycle
    input wire logic             counting      // run state
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////
    // any condition bit at all; a pulse with none high is a false count
    logic any_cond;
    assign any_cond = |{link_tx_single_flit_credit_stall, link_tx_multi_flit_credit_stall,
                        link_tx_header_buffer_state, link_rx_probe_tracker_stall,
                        dram_page_activate_count, dram_idle_page_close_count};

    ////////////////////////////////////////////////////////////////////////
    // one pulse adds exactly one, never two for several bits
    count_step_a: assert property (count_pulse && !cnt_clear |=> count == $past(count) + 1'b1)
        else $error("count did not step by one after a pulse");
    pulse_cause_a: assert property (count_pulse |-> $past(any_cond))
        else $error("pulse without any condition");
    legal_only_a: assert property (count_pulse |-> sel_legal)
        else $error("pulse under an unlisted selection");
    count_hold_a: assert property (!count_pulse && !cnt_clear |=> $stable(count))
        else $error("count moved without a pulse");
    cfg_refuse_a: assert property (count_pulse |-> !$past(cfg_write))
        else $error("pulse from a load cycle");
    clear_zero_a: assert property (cnt_clear |=> count == '0)
        else $error("clear did not zero the count");
    wrap_set_a: assert property ($past(count_pulse) && !$past(cnt_clear) && count == '0
        |-> ##[1:3] wrap_flag)
        else $error("wrap flag missing after wrap");
    flag_clear_a: assert property ($fell(wrap_flag) |-> $past(wrap_flag_clear))
        else $error("wrap flag fell without clear");
    run_start_a: assert property ($rose(counting) |-> $past(cnt_enable))
        else $error("run entered without enable");

    // main scenarios reached
    cover property (count_pulse && $past(link_tx_single_flit_credit_stall[2:0] == 3'h7));
    cover property ($rose(wrap_flag));
    cover property ($fell(counting));
endmodule

bind uec_top uec_monitor #(.CNT_W(CNT_W)) uec_monitor_i (
    .clk, .reset, .cfg_write, .cnt_enable, .cnt_clear, .wrap_flag_clear,
    .link_tx_single_flit_credit_stall, .link_tx_multi_flit_credit_stall,
    .link_tx_header_buffer_state, .link_rx_probe_tracker_stall,
    .dram_page_activate_count, .dram_idle_page_close_count,
    .count, .wrap_flag, .sel_legal, .count_pulse, .counting
);
`default_nettype wire

// ### test/uec_top_bench.sv
// self-checking bench for the uncore event qualifier
`timescale 1ns/1ps
`default_nettype none

module uec_top_bench;
    import uec_pkg::*;
    localparam int W = 4;          // short count so a wrap comes quickly
    typedef struct packed {
        logic [7:0]  ev;           // event number
        logic [7:0]  um;           // unit mask
        logic [23:0] cond;         // sf, mf, hdr, rx, act, pcl
        logic [1:0]  lh;           // listed, counts each cycle
    } uec_row_t;
    localparam uec_row_t ROWS [33] = '{
        '{8'h40, 8'h10, 24'h400000, 2'h3},
        '{8'h40, 8'h10, 24'h080000, 2'h2},
        '{8'h40, 8'h20, 24'h800000, 2'h3},
        '{8'h40, 8'h07, 24'h100000, 2'h3},
        '{8'h40, 8'h07, 24'h1c0000, 2'h3},
        '{8'h40, 8'h07, 24'he00000, 2'h2},
        '{8'h40, 8'h38, 24'h200000, 2'h3},
        '{8'h41, 8'h01, 24'h001000, 2'h3},
        '{8'h41, 8'h08, 24'h008000, 2'h3},
        '{8'h41, 8'h02, 24'h002000, 2'h3},
        '{8'h41, 8'h10, 24'h010000, 2'h3},
        '{8'h41, 8'h04, 24'h004000, 2'h3},
        '{8'h41, 8'h20, 24'h020000, 2'h3},
        '{8'h41, 8'h07, 24'h007000, 2'h3},
        '{8'h41, 8'h38, 24'h020000, 2'h3},
        '{8'h41, 8'h38, 24'h007000, 2'h2},
        '{8'h42, 8'h01, 24'h000100, 2'h3},
        '{8'h42, 8'h04, 24'h000400, 2'h3},
        '{8'h42, 8'h02, 24'h000200, 2'h3},
        '{8'h42, 8'h08, 24'h000800, 2'h3},
        '{8'h43, 8'h01, 24'h000040, 2'h3},
        '{8'h43, 8'h02, 24'h000080, 2'h3},
        '{8'h60, 8'h01, 24'h000008, 2'h3},
        '{8'h60, 8'h02, 24'h000010, 2'h3},
        '{8'h60, 8'h04, 24'h000020, 2'h3},
        '{8'h61, 8'h01, 24'h000001, 2'h3},
        '{8'h61, 8'h02, 24'h000002, 2'h3},
        '{8'h61, 8'h04, 24'h000004, 2'h3},
        '{8'h61, 8'h01, 24'h000008, 2'h2},
        '{8'h60, 8'h07, 24'h000038, 2'h0},
        '{8'h40, 8'h03, 24'hffffff, 2'h0},
        '{8'h62, 8'h01, 24'hffffff, 2'h0},
        '{8'h00, 8'h00, 24'hffffff, 2'h0}
    };

    logic         clk = 1'b0;
    logic         reset = 1'b1;
    logic         cfg_write = 1'b0;
    logic [7:0]   cfg_event = 8'h00;
    logic [7:0]   cfg_umask = 8'h00;
    logic         cnt_enable = 1'b0;
    logic         cnt_clear = 1'b0;
    logic         freeze_on_wrap = 1'b0;
    logic         wrap_flag_clear = 1'b0;
    logic [23:0]  cond = 24'h000000;
    logic [W-1:0] count;
    logic         wrap_flag;
    logic         sel_legal;
    logic         count_pulse;
    logic         counting;
    int           n_errors = 0;
    int           samples_checked = 0;
    int           cycles = 0;

    uec_top #(.CNT_W(W)) uec_top_i (
        .clk, .reset, .cfg_write, .cfg_event, .cfg_umask, .cnt_enable, .cnt_clear,
        .freeze_on_wrap, .wrap_flag_clear,
        .link_tx_single_flit_credit_stall(cond[23:18]),
        .link_tx_multi_flit_credit_stall(cond[17:12]),
        .link_tx_header_buffer_state(cond[11:8]),
        .link_rx_probe_tracker_stall(cond[7:6]),
        .dram_page_activate_count(cond[5:3]),
        .dram_idle_page_close_count(cond[2:0]),
        .count, .wrap_flag, .sel_legal, .count_pulse, .counting
    );

    ////////////////////////////////////////////////////////////////////////
    // 40 MHz clock and a hang guard well above the expected run
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_errors++;
            finish_test();
        end
    end

    // inputs always move 2 ns after the edge
    task automatic step(int n = 1);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // load a selection with a clear in the same cycle
    task automatic set_sel(logic [7:0] ev, logic [7:0] um);
        cfg_event = ev;
        cfg_umask = um;
        cfg_write = 1'b1;
        cnt_clear = 1'b1;
        step();
        cfg_write = 1'b0;
        cnt_clear = 1'b0;
    endtask

    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset, off state, table, then load, wrap and freeze corners
    initial begin
        step(2);
        reset = 1'b0;
        check("reset outs", 16'({count, wrap_flag, sel_legal, count_pulse, counting}), 16'h0);
        // off state refuses counting
        set_sel(8'h40, 8'h07);
        cond = 24'h040000;
        step(4);
        check("count off", 16'(count), 16'h0);
        cnt_enable = 1'b1;
        step();
        check("counting", 16'(counting), 16'h1);
        cond = '0;
        step(3);
        $display("test off done");
        foreach (ROWS[i]) begin
            set_sel(ROWS[i].ev, ROWS[i].um);
            cond = ROWS[i].cond;
            step(3);
            cond = '0;
            step(3);
            check("sel_legal", 16'(sel_legal), 16'(ROWS[i].lh[1]));
            check("count", 16'(count), ROWS[i].lh[0] ? 16'h3 : 16'h0);
        end
        $display("test table done");
        // load cycles held high refuse counting, first free edge counts
        cfg_event = 8'h40;
        cfg_umask = 8'h07;
        cfg_write = 1'b1;
        cnt_clear = 1'b1;
        cond = 24'h040000;
        step();
        cnt_clear = 1'b0;
        step(3);
        check("count load", 16'(count), 16'h0);
        cfg_write = 1'b0;
        step();
        check("count_pulse", 16'(count_pulse), 16'h1);
        step();
        check("count after load", 16'(count), 16'h1);
        cond = '0;
        step(3);
        $display("test load done");
        // nineteen counted cycles wrap a four bit count to three
        set_sel(8'h40, 8'h07);
        cond = 24'h040000;
        step(20);
        check("count wrap", 16'(count), 16'h3);
        check("wrap_flag", 16'(wrap_flag), 16'h1);
        cond = '0;
        wrap_flag_clear = 1'b1;
        step();
        wrap_flag_clear = 1'b0;
        check("wrap_flag clr", 16'(wrap_flag), 16'h0);
        $display("test wrap done");
        // freeze stops the count until a clear
        freeze_on_wrap = 1'b1;
        set_sel(8'h40, 8'h07);
        cond = 24'h040000;
        step(24);
        check("halted", 16'(counting), 16'h0);
        // wrap to zero, then the two increments already in the pipe land
        check("count halted", 16'(count), 16'h2);
        step(3);
        check("count frozen", 16'(count), 16'h2);
        cond = '0;
        cnt_clear = 1'b1;
        step();
        cnt_clear = 1'b0;
        check("count cleared", 16'(count), 16'h0);
        step(2);
        check("counting again", 16'(counting), 16'h1);
        $display("test freeze done");
        // dropping enable leaves run at the next edge
        cnt_enable = 1'b0;
        step();
        check("counting off", 16'(counting), 16'h0);
        $display("test disable done");
        // mid-run reset drops count, state, selection and the sticky flag
        cnt_enable = 1'b1;
        set_sel(8'h40, 8'h07);
        cond = 24'h040000;
        step(3);
        check("wrap_flag held", 16'(wrap_flag), 16'h1);
        reset = 1'b1;
        step();
        reset = 1'b0;
        check("reset mid", 16'({count, wrap_flag, sel_legal, count_pulse, counting}), 16'h0);
        step();
        check("count after reset", 16'(count), 16'h0);
        cond = '0;
        $display("test reset done");
        finish_test();
    end
endmodule
`default_nettype wire
